//--- qdp_pkg.sv
// Package: constants and types for the quad wiper control block
package qdp_pkg;

  localparam int QDP_NUM_CH = 4;
  localparam int QDP_NUM_TAPS = 256;
  localparam int QDP_NUM_SLOTS = 4;

  // System clock and nonvolatile write cycle time
  localparam int QDP_CLK_KHZ = 20000;
  localparam int QDP_WRITE_CYCLE_MS = 5;
  localparam int QDP_WRITE_CYCLES = QDP_WRITE_CYCLE_MS * QDP_CLK_KHZ;

  // Positions of the synchronised pins in the link-side pin vector
  localparam int QDP_PIN_SCL = 0;
  localparam int QDP_PIN_SDA = 1;
  localparam int QDP_PIN_CS_N = 2;
  localparam int QDP_PIN_DIR = 3;
  localparam int QDP_PIN_SEL_LO = 4;
  localparam int QDP_PIN_SEL_HI = 5;
  localparam int QDP_PIN_WP = 6;
  localparam int QDP_PIN_A0 = 7;
  localparam int QDP_PIN_A1 = 8;
  localparam int QDP_PIN_A2 = 9;
  localparam int QDP_PIN_W = 10;

  // Status register fields and address byte decode
  localparam int QDP_NV_BIT = 0;
  localparam int QDP_ROW_LO_BIT = 1;
  localparam int QDP_ROW_HI_BIT = 2;
  localparam logic [7:0] QDP_STATUS_RESET = 8'h00;
  localparam logic [2:0] QDP_ADDR_STATUS = 3'h7;
  localparam logic [1:0] QDP_SLOT_ZERO = 2'h0;
  localparam logic [7:0] QDP_STORED_INIT = 8'h80;

  // Bits per byte before the acknowledge clock
  localparam logic [3:0] QDP_BYTE_BITS = 4'h8;

  typedef enum logic [3:0] {
    QDP_IDLE,
    QDP_ADDR,
    QDP_ADDR_ACK,
    QDP_REG,
    QDP_REG_ACK,
    QDP_WDATA,
    QDP_WDATA_ACK,
    QDP_RDATA,
    QDP_RDATA_ACK
  } qdp_state_type;

endpackage

//--- qdp_wiper_ctrl.sv
// Quad wiper control: up/down stepping, two-wire slave and nonvolatile store timing
//
// Function
// (R1) Wiper code decodes one-hot onto 256 taps
// (R2) Zero selects low tap, ones high tap
// (R3) Four readable, writable stored slots per channel
// (R4) Reset loads slot zero into each wiper
// (R5) Chip select low: clock fall steps wiper
// (R6) Select pins pick channel, high pin MSB
// (R7) Chip select rise, clock high: store if protect high
// (R8) Host keeps row select zero before store
// (R9) Clock low at deselect: keep volatile only
// (R10) Deselected is standby; direction changes never step
// (R11) Two-wire bus ignored while chip select low
// (R12) Slave only, bytes most significant first
// (R13) Ignore traffic until a START is seen
// (R14) STOP ends every transaction, returns standby
// (R15) Data pin released after reset
// (R16) Release after eight bits, ack ninth clock
// (R17) Address matches type code and strap pins
// (R18) Ack matching address and every written byte
// (R19) Read continues only on master acknowledge
// (R20) Master sends STOP after a read nack
// (R21) Completed nonvolatile write starts timed busy cycle
// (R22) Busy withholds address ack; ack when done
// (R23) Status: two row bits, one target bit
// (R24) Stored write commits only if protect high
// (R25) Data line driven low or released only
`timescale 1ns/100ps
module qdp_wiper_ctrl #(
  // Device type code; value is arbitrary
  parameter logic [3:0] DEV_TYPE_ID = 4'hA,
  parameter int WRITE_CYCLES = qdp_pkg::QDP_WRITE_CYCLES
) (
  // System clock domain
  input wire logic clk_in,
  input wire logic srst_in,
  // Link sampling clock
  input wire logic link_clk_in,
  // Up/down and two-wire pins
  input wire logic cs_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  input wire logic dir_up_in,
  input wire logic channel_select_lo_in,
  input wire logic channel_select_hi_in,
  input wire logic write_protect_in,
  input wire logic addr_strap_0_in,
  input wire logic addr_strap_1_in,
  input wire logic addr_strap_2_in,
  // Tap switch selects
  output logic [qdp_pkg::QDP_NUM_TAPS-1:0] tap0_out,
  output logic [qdp_pkg::QDP_NUM_TAPS-1:0] tap1_out,
  output logic [qdp_pkg::QDP_NUM_TAPS-1:0] tap2_out,
  output logic [qdp_pkg::QDP_NUM_TAPS-1:0] tap3_out,
  // Nonvolatile write in progress
  output logic write_busy_out
);
  import qdp_pkg::*;
  function automatic logic [QDP_NUM_TAPS-1:0] tap_decode(input logic [7:0] code);
    logic [QDP_NUM_TAPS-1:0] r;
    r = '0;
    r[code] = 1'b1;
    return r;
  endfunction

  function automatic logic [7:0] step_sat(input logic [7:0] v, input logic up);
    logic [7:0] r;
    r = v;
    if (up && v != 8'hFF) begin
      r = v + 8'h01;
    end else if (!up && v != 8'h00) begin
      r = v - 8'h01;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: reset and pin synchronisers

  logic lrst_meta_q, lrst_q;
  logic [QDP_PIN_W-1:0] pin_meta_q, pin_q, pin_prev_q;
  logic [QDP_PIN_W-1:0] pin_raw;
  assign pin_raw = {addr_strap_2_in, addr_strap_1_in, addr_strap_0_in, write_protect_in,
                    channel_select_hi_in, channel_select_lo_in, dir_up_in, cs_n_in,
                    sda_in, scl_in};

  always_ff @(posedge link_clk_in) begin
    lrst_meta_q <= srst_in;
    lrst_q <= lrst_meta_q;
  end

  always_ff @(posedge link_clk_in) begin
    if (lrst_q) begin
      pin_meta_q <= '1;
      pin_q <= '1;
      pin_prev_q <= '1;
    end else begin
      pin_meta_q <= pin_raw;
      pin_q <= pin_meta_q;
      pin_prev_q <= pin_q;
    end
  end

  logic scl, sda, cs_n, scl_fall, scl_rise, cs_rise, bus_start, bus_stop;
  logic [1:0] ud_ch;
  logic [2:0] straps;
  logic wp;
  assign scl = pin_q[QDP_PIN_SCL];
  assign sda = pin_q[QDP_PIN_SDA];
  assign cs_n = pin_q[QDP_PIN_CS_N];
  assign wp = pin_q[QDP_PIN_WP];
  assign ud_ch = {pin_q[QDP_PIN_SEL_HI], pin_q[QDP_PIN_SEL_LO]}; // [R6]
  assign straps = {pin_q[QDP_PIN_A2], pin_q[QDP_PIN_A1], pin_q[QDP_PIN_A0]};
  assign scl_fall = pin_prev_q[QDP_PIN_SCL] && !scl;
  assign scl_rise = !pin_prev_q[QDP_PIN_SCL] && scl;
  assign cs_rise = !pin_prev_q[QDP_PIN_CS_N] && cs_n;
  // Data edges while the clock stays high frame a transaction
  assign bus_start = scl && pin_prev_q[QDP_PIN_SCL] && pin_prev_q[QDP_PIN_SDA] && !sda; // [R13]
  assign bus_stop = scl && pin_prev_q[QDP_PIN_SCL] && !pin_prev_q[QDP_PIN_SDA] && sda; // [R14]

  ////////////////////////////////////////////////////////////////////////////
  // Write cycle handshake between domains

  logic nv_req_q;
  logic ack_meta_q, ack_sync_q;
  logic ack_tgl_q;
  logic busy_l;
  always_ff @(posedge link_clk_in) begin
    if (lrst_q) begin
      ack_meta_q <= 1'b0;
      ack_sync_q <= 1'b0;
    end else begin
      ack_meta_q <= ack_tgl_q;
      ack_sync_q <= ack_meta_q;
    end
  end

  // Busy from request until the timer's answer returns
  assign busy_l = nv_req_q != ack_sync_q;
  logic req_meta_q, req_sync_q;
  logic [31:0] wc_cnt_q;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      req_meta_q <= 1'b0;
      req_sync_q <= 1'b0;
    end else begin
      req_meta_q <= nv_req_q;
      req_sync_q <= req_meta_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wc_cnt_q <= '0;
      ack_tgl_q <= 1'b0;
      write_busy_out <= 1'b0;
    end else begin
      write_busy_out <= req_sync_q != ack_tgl_q;
      if (req_sync_q != ack_tgl_q) begin
        if (wc_cnt_q == 32'(WRITE_CYCLES - 1)) begin
          wc_cnt_q <= '0;
          ack_tgl_q <= ~ack_tgl_q; // [R21]
        end else begin
          wc_cnt_q <= wc_cnt_q + 32'h00000001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers: wipers, stored slots, status

  logic [7:0] wiper_position_reg [QDP_NUM_CH];
  // Nonvolatile content survives reset; only a plain start value is given
  logic [7:0] stored_position_reg [QDP_NUM_CH][QDP_NUM_SLOTS] = '{default: QDP_STORED_INIT};
  logic [7:0] status_q;
  logic [1:0] row;
  logic nonvolatile_target;
  assign row = status_q[QDP_ROW_HI_BIT:QDP_ROW_LO_BIT]; // [R23]
  assign nonvolatile_target = status_q[QDP_NV_BIT];

  qdp_state_type state_q;
  logic [7:0] shift_q;
  logic [3:0] bit_cnt_q;
  logic rw_q;
  logic [2:0] ptr_q;
  logic drive_q;
  logic pend_q;
  logic [1:0] pend_ch_q;
  logic [7:0] pend_byte_q;
  logic i2c_wr, i2c_rd, ud_step, ud_store, stat_wr, dr_wr, addr_match;
  logic [7:0] rd_byte;
  assign i2c_wr = !lrst_q && cs_n && !bus_start && !bus_stop && state_q == QDP_WDATA
                  && scl_fall && bit_cnt_q == QDP_BYTE_BITS;
  assign stat_wr = i2c_wr && ptr_q == QDP_ADDR_STATUS;
  assign dr_wr = i2c_wr && !ptr_q[2] && nonvolatile_target;
  assign i2c_rd = !lrst_q && cs_n && !bus_start && !bus_stop && scl_fall
                  && ((state_q == QDP_ADDR_ACK && rw_q) || state_q == QDP_RDATA_ACK);
  assign ud_step = !lrst_q && !cs_n && scl_fall; // [R5] [R10]
  assign ud_store = !lrst_q && cs_rise && scl && wp; // [R7] [R9]
  assign addr_match = shift_q[7:4] == DEV_TYPE_ID && shift_q[3:1] == straps; // [R17]

  always_comb begin
    rd_byte = 8'h00;
    if (ptr_q == QDP_ADDR_STATUS) begin
      rd_byte = status_q;
    end else if (!ptr_q[2]) begin
      rd_byte = nonvolatile_target ? stored_position_reg[ptr_q[1:0]][row]
                                   : wiper_position_reg[ptr_q[1:0]]; // [R3]
    end
  end

  always_ff @(posedge link_clk_in) begin
    if (lrst_q) begin
      status_q <= QDP_STATUS_RESET;
    end else if (stat_wr) begin
      status_q <= {5'h00, shift_q[2:0]}; // [R23]
    end
  end

  always_ff @(posedge link_clk_in) begin
    for (int i = 0; i < QDP_NUM_CH; i++) begin
      if (lrst_q) begin
        wiper_position_reg[i] <= stored_position_reg[i][QDP_SLOT_ZERO]; // [R4]
      end else if (ud_step && ud_ch == 2'(i)) begin
        wiper_position_reg[i] <= step_sat(wiper_position_reg[i], pin_q[QDP_PIN_DIR]); // [R5]
      end else if (stat_wr && shift_q[QDP_NV_BIT]) begin
        // Selecting a stored row recalls that row into all wipers
        wiper_position_reg[i] <= stored_position_reg[i][shift_q[QDP_ROW_HI_BIT:QDP_ROW_LO_BIT]];
      end else if (i2c_wr && ptr_q == 3'(i)) begin
        wiper_position_reg[i] <= shift_q; // [R3]
      end else if (dr_wr) begin
        wiper_position_reg[i] <= stored_position_reg[i][row];
      end else if (i2c_rd && nonvolatile_target && ptr_q == 3'(i)) begin
        wiper_position_reg[i] <= stored_position_reg[i][row];
      end
    end
  end

  always_ff @(posedge link_clk_in) begin
    if (ud_store) begin
      stored_position_reg[ud_ch][QDP_SLOT_ZERO] <= wiper_position_reg[ud_ch]; // [R7]
    end else if (!lrst_q && cs_n && bus_stop && pend_q && wp) begin
      stored_position_reg[pend_ch_q][row] <= pend_byte_q; // [R24]
    end
  end

  // Pending stored write waits for the STOP that ends its sequence
  always_ff @(posedge link_clk_in) begin
    if (lrst_q || bus_start || bus_stop || !cs_n) begin
      pend_q <= 1'b0;
      pend_ch_q <= 2'h0;
      pend_byte_q <= 8'h00;
    end else if (dr_wr) begin
      pend_q <= 1'b1;
      pend_ch_q <= ptr_q[1:0];
      pend_byte_q <= shift_q;
    end
  end

  always_ff @(posedge link_clk_in) begin
    if (lrst_q) begin
      nv_req_q <= 1'b0;
    end else if (ud_store || (cs_n && bus_stop && pend_q && wp)) begin
      nv_req_q <= ~nv_req_q; // [R21] [R24]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-wire slave

  always_ff @(posedge link_clk_in) begin
    if (lrst_q) begin
      state_q <= QDP_IDLE;
      shift_q <= 8'h00;
      bit_cnt_q <= 4'h0;
      rw_q <= 1'b0;
      ptr_q <= 3'h0;
      drive_q <= 1'b0; // [R15]
    end else if (!cs_n) begin
      state_q <= QDP_IDLE; // [R11]
      drive_q <= 1'b0;
    end else if (bus_start) begin
      state_q <= QDP_ADDR; // [R13]
      bit_cnt_q <= 4'h0;
      drive_q <= 1'b0;
    end else if (bus_stop) begin
      state_q <= QDP_IDLE; // [R14]
      drive_q <= 1'b0;
    end else begin
      case (state_q)
        QDP_IDLE: begin
          drive_q <= 1'b0;
        end
        QDP_ADDR, QDP_REG, QDP_WDATA: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda}; // [R12]
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == QDP_BYTE_BITS) begin
            drive_q <= 1'b1; // [R16] [R18]
            case (state_q)
              QDP_ADDR: begin
                if (addr_match && !busy_l) begin
                  rw_q <= shift_q[0];
                  state_q <= QDP_ADDR_ACK; // [R22]
                end else begin
                  drive_q <= 1'b0;
                  state_q <= QDP_IDLE;
                end
              end
              QDP_REG: begin
                ptr_q <= shift_q[2:0];
                state_q <= QDP_REG_ACK;
              end
              default: begin
                state_q <= QDP_WDATA_ACK;
              end
            endcase
          end
        end
        QDP_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_q) begin
              shift_q <= rd_byte;
              drive_q <= !rd_byte[7]; // [R12]
              bit_cnt_q <= 4'h1;
              state_q <= QDP_RDATA;
            end else begin
              drive_q <= 1'b0;
              bit_cnt_q <= 4'h0;
              state_q <= QDP_REG;
            end
          end
        end
        QDP_REG_ACK, QDP_WDATA_ACK: begin
          if (scl_fall) begin
            drive_q <= 1'b0; // [R16]
            bit_cnt_q <= 4'h0;
            state_q <= QDP_WDATA;
          end
        end
        QDP_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt_q == QDP_BYTE_BITS) begin
              drive_q <= 1'b0; // [R16]
              state_q <= QDP_RDATA_ACK;
            end else begin
              shift_q <= {shift_q[6:0], 1'b0};
              drive_q <= !shift_q[6];
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
        end
        QDP_RDATA_ACK: begin
          if (scl_rise && sda) begin
            state_q <= QDP_IDLE; // [R19] [R20]
          end else if (scl_fall) begin
            shift_q <= rd_byte; // [R19]
            drive_q <= !rd_byte[7];
            bit_cnt_q <= 4'h1;
            state_q <= QDP_RDATA;
          end
        end
        default: begin
          state_q <= QDP_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  always_ff @(posedge link_clk_in) begin
    if (lrst_q) begin
      sda_out <= 1'b0;
      sda_oe_n_out <= 1'b1; // [R15]
    end else begin
      sda_out <= 1'b0; // [R25]
      sda_oe_n_out <= !drive_q;
    end
  end

  always_ff @(posedge link_clk_in) begin
    tap0_out <= tap_decode(wiper_position_reg[0]); // [R1] [R2]
    tap1_out <= tap_decode(wiper_position_reg[1]);
    tap2_out <= tap_decode(wiper_position_reg[2]);
    tap3_out <= tap_decode(wiper_position_reg[3]);
  end

endmodule

//--- qdp_wiper_props.sv
// Checker: port properties of the quad wiper control
`timescale 1ns/100ps
module qdp_wiper_props #(
  parameter int WRITE_CYCLES = 50
) (
  // Clocks, reset and pins
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic link_clk_in,
  input wire logic cs_n_in,
  input wire logic scl_in,
  input wire logic dir_up_in,
  input wire logic channel_select_lo_in,
  input wire logic channel_select_hi_in,
  // Outputs
  input wire logic sda_out,
  input wire logic sda_oe_n_out,
  input wire logic [qdp_pkg::QDP_NUM_TAPS-1:0] tap0_out,
  input wire logic [qdp_pkg::QDP_NUM_TAPS-1:0] tap3_out,
  input wire logic write_busy_out
);
  import qdp_pkg::*;
  logic [QDP_NUM_TAPS-1:0] snap_q;
  int busy_cnt_q;
  // Tap before each step, so the shift can be checked later
  always_ff @(posedge link_clk_in)
    if (!cs_n_in && $fell(scl_in))
      snap_q <= tap0_out;
  always_ff @(posedge clk_in)
    busy_cnt_q <= (srst_in || !write_busy_out) ? 0 : busy_cnt_q + 1;
  sequence s_up0;
    !cs_n_in && $fell(scl_in) && dir_up_in && !channel_select_lo_in && !channel_select_hi_in;
  endsequence
  property p_step;
    @(posedge link_clk_in) disable iff (srst_in)
    s_up0 ##0 !tap0_out[255] |-> ##[2:10] tap0_out == (snap_q << 1);
  endproperty
  a_step: assert property (p_step) else $error("step up missed");
  property p_onehot;
    @(posedge link_clk_in) disable iff (srst_in) $onehot(tap0_out) && $onehot(tap3_out);
  endproperty
  a_onehot: assert property (p_onehot) else $error("tap not one-hot");
  property p_low_only;
    @(posedge link_clk_in) disable iff (srst_in) !sda_oe_n_out |-> !sda_out;
  endproperty
  a_low_only: assert property (p_low_only) else $error("data driven high");
  property p_cs_off;
    @(posedge link_clk_in) disable iff (srst_in) !cs_n_in [*8] |-> sda_oe_n_out;
  endproperty
  a_cs_off: assert property (p_cs_off) else $error("data driven while selected");
  property p_boot;
    @(posedge link_clk_in) disable iff (srst_in) $fell(srst_in) |-> sda_oe_n_out [*4];
  endproperty
  a_boot: assert property (p_boot) else $error("data driven after reset");
  property p_grab;
    @(posedge link_clk_in) disable iff (srst_in) $fell(sda_oe_n_out) |-> !scl_in;
  endproperty
  a_grab: assert property (p_grab) else $error("data taken with clock high");
  property p_free;
    @(posedge link_clk_in) disable iff (srst_in) $rose(sda_oe_n_out) |-> !scl_in;
  endproperty
  a_free: assert property (p_free) else $error("data freed with clock high");
  property p_busy_quiet;
    @(posedge link_clk_in) disable iff (srst_in) write_busy_out |-> sda_oe_n_out;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("answer while busy");
  property p_busy_hold;
    @(posedge clk_in) disable iff (srst_in) $rose(write_busy_out) |=> write_busy_out [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy too short");
  property p_busy_len;
    @(posedge clk_in) disable iff (srst_in) $fell(write_busy_out) |->
      busy_cnt_q + 2 >= WRITE_CYCLES && busy_cnt_q <= WRITE_CYCLES + 8;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length off");
endmodule
bind qdp_wiper_ctrl qdp_wiper_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (.clk_in, .srst_in,
  .link_clk_in, .cs_n_in, .scl_in, .dir_up_in, .channel_select_lo_in, .channel_select_hi_in,
  .sda_out, .sda_oe_n_out, .tap0_out, .tap3_out, .write_busy_out);

//--- qdp_host.sv
// Host model: two-wire master and up/down driver
`timescale 1ns/100ps
module qdp_host (
  // Clock and resolved data line
  input wire logic clk_in,
  input wire logic sda_in,
  // Driven pins
  output logic scl_out,
  output logic sda_low_out,
  output logic cs_n_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
    cs_n_out = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Data set mid-low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    wt(8);
    sda_low_out <= !b;
    wt(8);
    scl_out <= 1'b1;
    wt(4);
    r = sda_in;
    wt(4);
    scl_out <= 1'b0;
  endtask
  task automatic start();
    wt(8);
    sda_low_out <= 1'b0;
    wt(8);
    scl_out <= 1'b1;
    wt(8);
    sda_low_out <= 1'b1;
    wt(8);
    scl_out <= 1'b0;
  endtask
  task automatic stop();
    wt(8);
    sda_low_out <= 1'b1;
    wt(8);
    scl_out <= 1'b1;
    wt(8);
    sda_low_out <= 1'b0;
    wt(8);
  endtask
  // Release of 1 on the ninth bit lets the slave answer
  task automatic xfer(input logic [7:0] tx, input logic rel, output logic [7:0] rx,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(rel, r);
    ack = !r;
  endtask
  // Deselects with the clock low unless a store is wanted
  task automatic ud(input int n, input logic st);
    wt(8);
    cs_n_out <= 1'b0;
    for (int i = 0; i < n; i++) begin
      wt(8);
      scl_out <= 1'b0;
      if (i < n - 1 || st) begin
        wt(8);
        scl_out <= 1'b1;
      end
    end
    wt(8);
    cs_n_out <= 1'b1;
    wt(8);
    scl_out <= 1'b1;
    wt(8);
  endtask
endmodule

//--- testbench.sv
// Testbench: wiper control against a register model
`timescale 1ns/100ps
module testbench;
  import qdp_pkg::*;
  localparam logic [3:0] DEV = 4'hA; // Arbitrary type code
  localparam int WC = 400;
  logic clk_in, srst_in, link_clk_in, cs_n_in, scl_in, sda_in, sda_out, sda_oe_n_out, sda_low;
  logic dir_up_in, channel_select_lo_in, channel_select_hi_in, write_protect_in, write_busy_out;
  logic addr_strap_0_in, addr_strap_1_in, addr_strap_2_in;
  logic [QDP_NUM_TAPS-1:0] tap0_out, tap1_out, tap2_out, tap3_out;
  logic [7:0] wm [4];
  logic [7:0] sm [4];
  logic [2:0] strap;
  int err_count, compares, c;
  assign sda_in = !(sda_low || (!sda_oe_n_out && !sda_out));
  assign {addr_strap_2_in, addr_strap_1_in, addr_strap_0_in} = strap;
  qdp_host host (.clk_in, .sda_in, .scl_out(scl_in), .sda_low_out(sda_low), .cs_n_out(cs_n_in));
  qdp_wiper_ctrl #(.DEV_TYPE_ID(DEV), .WRITE_CYCLES(WC)) dut (.clk_in, .srst_in, .link_clk_in,
    .cs_n_in, .scl_in, .sda_in, .sda_out, .sda_oe_n_out, .dir_up_in, .channel_select_lo_in,
    .channel_select_hi_in, .write_protect_in, .addr_strap_0_in, .addr_strap_1_in,
    .addr_strap_2_in, .tap0_out, .tap1_out, .tap2_out, .tap3_out, .write_busy_out);
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  initial begin
    link_clk_in = 1'b0;
    #17;
    forever #32 link_clk_in = ~link_clk_in;
  end
  //////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_taps();
    logic [QDP_NUM_TAPS-1:0] t [4];
    t = '{tap0_out, tap1_out, tap2_out, tap3_out};
    for (int i = 0; i < 4; i++) begin
      compares++;
      if (t[i] !== (256'h1 << wm[i])) begin
        err_count++;
        $display("wrong value tap%0d expected %0d seen %h", i, wm[i], t[i]);
      end
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  //////////////////////////////
  task automatic ud(input int ch, input logic up, input int n, input logic st);
    @(posedge clk_in);
    {channel_select_hi_in, channel_select_lo_in} <= 2'(ch);
    dir_up_in <= up;
    host.ud(n, st);
    for (int i = 0; i < n; i++)
      if (up && wm[ch] != 8'hFF) wm[ch]++;
      else if (!up && wm[ch] != 8'h00) wm[ch]--;
    if (st && write_protect_in) sm[ch] = wm[ch];
  endtask
  task automatic wr_reg(input logic [7:0] ra, input logic [7:0] d);
    logic [7:0] b [3];
    logic [7:0] rx;
    logic a;
    b = '{{DEV, strap, 1'b0}, ra, d};
    host.start();
    for (int k = 0; k < 3; k++) begin
      host.xfer(b[k], 1'b1, rx, a);
      chk("write ack", 8'h01, {7'h00, a});
    end
    host.stop();
  endtask
  task automatic rd_reg(input logic [7:0] ra, input logic [7:0] e);
    logic [7:0] rx;
    logic a;
    host.start();
    host.xfer({DEV, strap, 1'b0}, 1'b1, rx, a);
    host.xfer(ra, 1'b1, rx, a);
    host.start();
    host.xfer({DEV, strap, 1'b1}, 1'b1, rx, a);
    host.xfer(8'hFF, 1'b0, rx, a);
    chk("read data", e, rx);
    host.xfer(8'hFF, 1'b1, rx, a);
    chk("read repeat", e, rx);
    host.stop();
  endtask
  task automatic poll(input logic [7:0] ab, input logic e);
    logic [7:0] rx;
    logic a;
    host.start();
    host.xfer(ab, 1'b1, rx, a);
    chk("poll ack", {7'h00, e}, {7'h00, a});
    host.stop();
  endtask
  task automatic wait_idle();
    for (int i = 0; i < WC + 100 && write_busy_out !== 1'b0; i++) @(posedge clk_in);
    chk("busy end", 8'h00, {7'h00, write_busy_out});
    host.wt(20);
  endtask
  //////////////////////////////
  initial begin
    repeat (40000) @(posedge clk_in);
    err_count++;
    tally_and_finish();
  end
  initial begin
    srst_in = 1'b1;
    dir_up_in = 1'b0;
    channel_select_lo_in = 1'b0;
    channel_select_hi_in = 1'b0;
    write_protect_in = 1'b1;
    void'($urandom(32'h109B4437));
    strap = 3'($urandom);
    for (int i = 0; i < 4; i++) begin
      wm[i] = QDP_STORED_INIT;
      sm[i] = QDP_STORED_INIT;
    end
    repeat (8) @(posedge clk_in);
    srst_in <= 1'b0;
    host.wt(10);
    chk_taps();
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      ud(i, 1'b1, 1 + $urandom % 4, 1'b0);
      ud(i, 1'b0, 1 + $urandom % 6, 1'b0);
      chk_taps();
    end
    ud($urandom % 4, 1'b1, 130, 1'b0);
    chk_taps();
    c = $urandom % 4;
    ud(c, 1'b0, 2, 1'b1); // Status rows still zero here
    chk("store busy", 8'h01, {7'h00, write_busy_out});
    wait_idle();
    write_protect_in <= 1'b0;
    ud(c, 1'b1, 1, 1'b1);
    chk("no store busy", 8'h00, {7'h00, write_busy_out});
    // Ten clock falls while selected step the wiper; the slave stays deaf
    host.cs_n_out <= 1'b0;
    poll({DEV, strap, 1'b0}, 1'b0);
    host.cs_n_out <= 1'b1;
    wm[c] = (wm[c] > 8'hF5) ? 8'hFF : wm[c] + 8'h0A;
    host.wt(20);
    chk_taps();
    write_protect_in <= 1'b1;
    $display("test up down done");
    c = $urandom % 4;
    wm[c] = 8'($urandom);
    wr_reg(8'(c), wm[c]);
    chk_taps();
    for (int k = 0; k < 4; k++) poll({DEV, strap, 1'b0} ^ (8'h02 << k), 1'b0);
    rd_reg(8'(c), wm[c]);
    wr_reg({5'h00, QDP_ADDR_STATUS}, 8'h01);
    wm = sm;
    chk_taps();
    rd_reg({5'h00, QDP_ADDR_STATUS}, 8'h01);
    $display("test serial done");
    c = $urandom % 4;
    sm[c] = 8'($urandom);
    wm[c] = sm[c];
    wr_reg(8'(c), sm[c]);
    poll({DEV, strap, 1'b1}, 1'b0);
    chk("write busy", 8'h01, {7'h00, write_busy_out});
    wait_idle();
    poll({DEV, strap, 1'b0}, 1'b1);
    write_protect_in <= 1'b0;
    wm[c] = ~sm[c];
    wr_reg(8'(c), wm[c]);
    chk("protected busy", 8'h00, {7'h00, write_busy_out});
    chk_taps();
    write_protect_in <= 1'b1;
    rd_reg(8'(c), sm[c]);
    wm[c] = sm[c];
    chk_taps();
    wr_reg({5'h00, QDP_ADDR_STATUS}, 8'h03);
    wm = '{4{QDP_STORED_INIT}};
    chk_taps();
    rd_reg({5'h00, QDP_ADDR_STATUS}, 8'h03);
    rd_reg(8'(c), QDP_STORED_INIT);
    $display("test stored done");
    tally_and_finish();
  end
endmodule
